// File: cac_config.v
/*
  cac_config.v: serial configuration registers, field decode and 10-bit
  output coding (binary, gray, differential) of the camera front-end.
  assumes CLOCK at 50 MHz, serial pins and sample pulses asynchronous,
  line start marked by the optical black pulse.
*/
`timescale 1ns/10ps
`include "cac_consts.vh"

// Function
// R1: gain code steers sampling-mode amplifier gain
// R2: same gain code, linear in direct mode
// R3: bit 15 picks sampling or direct input
// R4: sleep bit stops all circuits
// R5: standby keeps only reference generator running
// R6: host keeps output test bits zero
// R7: two-bit sample-hold filter select
// R8: four-bit black-sample time constant
// R9: clamp code equals twice field plus 14
// R10: clamp field resets to 9, code 32
// R11: gain step of one enables fast lead-in
// R12: bit 12 selects low-power mode
// R13: polarity bit: one normal, zero inverts pulses
// R14: software reset active low, released high
// R15: center bias off in direct mode
// R16: clamp detection averaged over four lines
// R17: output code binary, gray, differential
// R18: reference word position from timing bits
// R19: optical black edge select rise or fall
// R20: receiver rebuilds codes from differential words
// R21: gray or differential advised against ripple
// R22: sixteen serial clocks under chip select low
// R23: aborted frame discarded
// R24: data latched on serial clock rising edge
// R25: gray is reflected binary conversion
// R26: differential words modulo 1024, reference full
module cac_config (
  // clock and reset
  input wire CLOCK,
  input wire NRST,
  // serial link
  input wire SERIAL_CS_N,
  input wire SERIAL_CLK,
  input wire SERIAL_DATA_IN,
  // timing pulses and converter data
  input wire CONVERTER_CLOCK,
  input wire SIGNAL_SAMPLE_PULSE,
  input wire BLACK_SAMPLE_PULSE,
  input wire PREBLANK_INPUT,
  input wire OPTICAL_BLACK_PULSE,
  input wire [9:0] ADC_CODE,
  // decoded controls
  output reg [7:0] GAIN_CODE,
  output reg INPUT_PATH_SELECT,
  output reg SLEEP_REQUEST,
  output reg STANDBY_REQUEST,
  output reg [2:0] OUTPUT_TEST_BITS,
  output reg [1:0] SH_FILTER_SELECT,
  output reg [3:0] BLACK_SAMPLE_TIME_CONSTANT,
  output reg [9:0] CLAMP_LEVEL_CODE,
  output reg [1:0] FAST_LEADIN_CANCEL_TIME,
  output reg [1:0] FAST_LEADIN_GAIN_MULTIPLIER,
  output reg FAST_LEADIN_ACTIVE,
  output reg LOW_POWER_SELECT,
  output reg SOFT_RESET_N,
  output reg CENTER_BIAS_OFF,
  output reg CLAMP_FOUR_LINE_AVERAGE,
  output reg OUTPUT_TEST_BIT_C,
  // conditioned pulses
  output reg SIGNAL_SAMPLE,
  output reg BLACK_SAMPLE,
  output reg PREBLANK,
  output reg OB_STROBE,
  // coded output
  output reg [9:0] DATA_OUT,
  output reg DATA_VALID,
  output reg DATA_IS_REFERENCE
);

  function [9:0] to_gray;
    input [9:0] b;
    begin
      to_gray = b ^ {1'b0, b[9:1]};
    end
  endfunction

  localparam ST_IDLE = 2'b01;
  localparam ST_SHIFT = 2'b10;

  // two-flop synchronisers for every foreign input
  reg [1:0] cs_s1_q, sck_s1_q, sd_s1_q, cck_s1_q;
  reg [1:0] cs_s2_q, sck_s2_q, sd_s2_q, cck_s2_q;
  reg sck_prev_q, cck_prev_q, ob_prev_q;
  reg [3:0] pls_s1_q, pls_s2_q;
  reg [9:0] code_s1_q, code_s2_q;

  reg [1:0] state_q;
  reg [4:0] cnt_q;
  reg [15:0] shift_q;
  reg [15:0] reg0_q, reg1_q, reg2_q, reg3_q;
  reg [7:0] gain_prev_q;
  reg [9:0] prev_code_q;
  reg [3:0] pos_q;
  // optical black level at the previous accepted converter edge
  reg ob_edge_q;

  wire cs_n = cs_s2_q[0];
  wire sck = sck_s2_q[0];
  wire sd = sd_s2_q[0];
  wire cck = cck_s2_q[0];
  wire sck_rise = sck & ~sck_prev_q;
  wire [15:0] frame = {shift_q[14:0], sd};

  // one bit of each sync pair is used; spares kept at width for symmetry
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      cs_s1_q <= 2'h3;
      cs_s2_q <= 2'h3;
      sck_s1_q <= 2'h0;
      sck_s2_q <= 2'h0;
      sd_s1_q <= 2'h0;
      sd_s2_q <= 2'h0;
      cck_s1_q <= 2'h0;
      cck_s2_q <= 2'h0;
      pls_s1_q <= 4'h0;
      pls_s2_q <= 4'h0;
      code_s1_q <= 10'h000;
      code_s2_q <= 10'h000;
      sck_prev_q <= 1'b0;
      cck_prev_q <= 1'b0;
    end else begin
      cs_s1_q <= {1'b1, SERIAL_CS_N};
      cs_s2_q <= cs_s1_q;
      sck_s1_q <= {1'b0, SERIAL_CLK};
      sck_s2_q <= sck_s1_q;
      sd_s1_q <= {1'b0, SERIAL_DATA_IN};
      sd_s2_q <= sd_s1_q;
      cck_s1_q <= {1'b0, CONVERTER_CLOCK};
      cck_s2_q <= cck_s1_q;
      pls_s1_q <= {OPTICAL_BLACK_PULSE, PREBLANK_INPUT, BLACK_SAMPLE_PULSE,
                   SIGNAL_SAMPLE_PULSE};
      pls_s2_q <= pls_s1_q;
      code_s1_q <= ADC_CODE;
      code_s2_q <= code_s1_q;
      sck_prev_q <= sck;
      cck_prev_q <= cck;
    end
  end

  // serial receiver: msb first, 3-bit address in the low byte
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
      shift_q <= 16'h0000;
      reg0_q <= `CAC_RST_GAIN;
      reg1_q <= `CAC_RST_POWER;
      reg2_q <= `CAC_RST_CLAMP; // R10
      reg3_q <= `CAC_RST_OUTCODE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cnt_q <= 5'h00;
          if (!cs_n) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (cs_n) begin
            // chip select lost before the last bit: nothing is stored
            state_q <= ST_IDLE; // R23
          end else if (sck_rise) begin // R24
            shift_q <= frame;
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'd15) begin // R22
              state_q <= ST_IDLE;
              case (frame[`CAC_ADDR_W-1:0])
                `CAC_ADDR_GAIN: reg0_q <= {frame[15:8], frame[7:0]};
                `CAC_ADDR_POWER: reg1_q <= frame;
                `CAC_ADDR_CLAMP: reg2_q <= frame;
                `CAC_ADDR_OUTCODE: reg3_q <= frame;
                default: ;
              endcase
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // frame byte order on the wire is high byte first; registers are used as received
  wire [15:0] r0 = reg0_q;
  wire [15:0] r1 = reg1_q;
  wire [15:0] r2 = reg2_q;
  wire [15:0] r3 = reg3_q;
  wire [1:0] code_sel = r3[`CAC_CODE_MSB:`CAC_CODE_LSB];
  wire sp_norm = r2[`CAC_SPPOL_BIT];
  wire ob_in = pls_s2_q[3];
  wire cck_edge = r3[`CAC_OBEDGE_BIT] ? (~cck & cck_prev_q) : (cck & ~cck_prev_q);
  wire [3:0] ref_pos = `CAC_REF_BASE + {2'b00, r3[`CAC_REFT_MSB:`CAC_REFT_LSB]};
  // line start is judged at converter edges, so a black pulse falling between two edges is missed
  wire ob_new = ob_in & ~ob_edge_q;
  wire [3:0] pos_d = ob_new ? 4'h1 : ((pos_q == 4'hF) ? pos_q : pos_q + 4'h1);
  wire is_ref = (pos_d == ref_pos) || (pos_d == ref_pos + 4'h1);
  wire run = r2[`CAC_SWRST_BIT] & ~r1[`CAC_SLEEP_BIT];
  wire [7:0] gain_now = r0[`CAC_GAIN_MSB:`CAC_GAIN_LSB];
  wire [9:0] diff = code_s2_q - prev_code_q;

  // decoded control outputs
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      GAIN_CODE <= 8'h00;
      INPUT_PATH_SELECT <= 1'b0;
      SLEEP_REQUEST <= 1'b0;
      STANDBY_REQUEST <= 1'b0;
      OUTPUT_TEST_BITS <= 3'h0;
      SH_FILTER_SELECT <= 2'h0;
      BLACK_SAMPLE_TIME_CONSTANT <= 4'h0;
      CLAMP_LEVEL_CODE <= 10'h020;
      FAST_LEADIN_CANCEL_TIME <= 2'h0;
      FAST_LEADIN_GAIN_MULTIPLIER <= 2'h0;
      FAST_LEADIN_ACTIVE <= 1'b0;
      LOW_POWER_SELECT <= 1'b0;
      SOFT_RESET_N <= 1'b1;
      CENTER_BIAS_OFF <= 1'b0;
      CLAMP_FOUR_LINE_AVERAGE <= 1'b0;
      OUTPUT_TEST_BIT_C <= 1'b0;
      gain_prev_q <= 8'h00;
    end else begin
      GAIN_CODE <= gain_now; // R1 R2
      INPUT_PATH_SELECT <= r0[`CAC_PATH_BIT]; // R3
      SLEEP_REQUEST <= r1[`CAC_SLEEP_BIT]; // R4
      STANDBY_REQUEST <= r1[`CAC_STANDBY_REQUEST_BIT]; // R5
      // passed through unchanged; keeping them zero is the host's job
      OUTPUT_TEST_BITS <= r1[`CAC_OTEST_MSB:`CAC_OTEST_LSB]; // R6
      OUTPUT_TEST_BIT_C <= r3[`CAC_CODE_LSB];
      SH_FILTER_SELECT <= r1[`CAC_FSEL_MSB:`CAC_FSEL_LSB]; // R7
      BLACK_SAMPLE_TIME_CONSTANT <= r1[`CAC_BTC_MSB:`CAC_BTC_LSB]; // R8
      CLAMP_LEVEL_CODE <= {4'h0, r2[`CAC_CLAMP_MSB:`CAC_CLAMP_LSB], 1'b0}
                          + `CAC_CLAMP_OFFSET; // R9
      FAST_LEADIN_CANCEL_TIME <= r2[`CAC_LCAN_MSB:`CAC_LCAN_LSB];
      FAST_LEADIN_GAIN_MULTIPLIER <= r2[`CAC_LMUL_MSB:`CAC_LMUL_LSB];
      LOW_POWER_SELECT <= r2[`CAC_LOWPWR_BIT]; // R12
      SOFT_RESET_N <= r2[`CAC_SWRST_BIT]; // R14
      CENTER_BIAS_OFF <= r0[`CAC_PATH_BIT] & r3[`CAC_CBIAS_BIT]; // R15
      CLAMP_FOUR_LINE_AVERAGE <= r3[`CAC_AVG4_BIT]; // R16
      // gain sampled once per line, at each optical black start
      if (ob_in & ~ob_prev_q) begin
        gain_prev_q <= gain_now;
        FAST_LEADIN_ACTIVE <= (gain_now == gain_prev_q + 8'h01) ||
                              (gain_now + 8'h01 == gain_prev_q); // R11
      end
    end
  end

  // pulse conditioning and output coding
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      SIGNAL_SAMPLE <= 1'b0;
      BLACK_SAMPLE <= 1'b0;
      PREBLANK <= 1'b0;
      OB_STROBE <= 1'b0;
      ob_prev_q <= 1'b0;
      pos_q <= 4'h0;
      ob_edge_q <= 1'b0;
      prev_code_q <= 10'h000;
      DATA_OUT <= 10'h000;
      DATA_VALID <= 1'b0;
      DATA_IS_REFERENCE <= 1'b0;
    end else begin
      SIGNAL_SAMPLE <= pls_s2_q[0] ~^ sp_norm; // R13
      BLACK_SAMPLE <= pls_s2_q[1] ~^ sp_norm; // R13
      PREBLANK <= pls_s2_q[2] ~^ sp_norm; // R13
      OB_STROBE <= ob_in & cck_edge; // R19
      ob_prev_q <= ob_in;
      DATA_VALID <= cck_edge & run;
      if (cck_edge & run) begin
        // position counts from 1 after each optical black rise, saturating
        pos_q <= pos_d;
        ob_edge_q <= ob_in;
        prev_code_q <= code_s2_q;
        DATA_IS_REFERENCE <= is_ref; // R18
        case (code_sel) // R17
          `CAC_CODE_BIN: DATA_OUT <= code_s2_q;
          `CAC_CODE_GRAY: DATA_OUT <= to_gray(code_s2_q); // R25
          `CAC_CODE_DBIN: DATA_OUT <= is_ref ? code_s2_q : diff; // R26
          `CAC_CODE_DGRAY: DATA_OUT <= to_gray(is_ref ? code_s2_q : diff); // R26
          default: DATA_OUT <= code_s2_q;
        endcase
      end
    end
  end

endmodule

// File: cac_consts.vh
/*
  cac_consts.vh: register addresses, field positions, reset values and
  timing constants of the camera front-end configuration block.
  assumes inclusion by its bare name from the design file.
*/
`ifndef CAC_CONSTS_VH
`define CAC_CONSTS_VH

// serial frame
`define CAC_FRAME_BITS 16
`define CAC_ADDR_W 3

// register addresses carried in the frame
`define CAC_ADDR_GAIN 3'h0
`define CAC_ADDR_POWER 3'h1
`define CAC_ADDR_CLAMP 3'h2
`define CAC_ADDR_OUTCODE 3'h3

// gain and input select
`define CAC_GAIN_LSB 5
`define CAC_GAIN_MSB 12
`define CAC_PATH_BIT 15

// power and filter
`define CAC_SLEEP_BIT 3
`define CAC_STANDBY_REQUEST_BIT 4
`define CAC_OTEST_LSB 5
`define CAC_OTEST_MSB 7
`define CAC_FSEL_LSB 8
`define CAC_FSEL_MSB 9
`define CAC_BTC_LSB 10
`define CAC_BTC_MSB 13

// clamp and mode
`define CAC_CLAMP_LSB 3
`define CAC_CLAMP_MSB 7
`define CAC_LCAN_LSB 8
`define CAC_LCAN_MSB 9
`define CAC_LMUL_LSB 10
`define CAC_LMUL_MSB 11
`define CAC_LOWPWR_BIT 12
`define CAC_SPPOL_BIT 13
`define CAC_SWRST_BIT 15

// output code control
`define CAC_CBIAS_BIT 3
`define CAC_CODE_LSB 4
`define CAC_CODE_MSB 5
`define CAC_AVG4_BIT 6
`define CAC_REFT_LSB 7
`define CAC_REFT_MSB 8
`define CAC_OBEDGE_BIT 9

// reset values: clamp field 9, software reset released, normal polarity
`define CAC_RST_GAIN 16'h0000
`define CAC_RST_POWER 16'h0000
`define CAC_RST_CLAMP 16'hA048
`define CAC_RST_OUTCODE 16'h0000

// clamp code = 2 * field + 14
`define CAC_CLAMP_OFFSET 10'h00E

// output codes
`define CAC_CODE_BIN 2'h0
`define CAC_CODE_GRAY 2'h1
`define CAC_CODE_DBIN 2'h2
`define CAC_CODE_DGRAY 2'h3

// first reference position for timing code 0
`define CAC_REF_BASE 4'h3
`define CAC_POS_W 4

`endif

// File: cac_props.sv
/*
  cac_props.sv: checker for the configuration and output coding block.
  assumes it is bound to every cac_config instance, ports named alike.
*/
`timescale 1ns/10ps
module cac_props (
  // clock and reset
  input wire CLOCK,
  input wire NRST,
  // watched pins
  input wire SERIAL_CS_N,
  input wire [7:0] GAIN_CODE,
  input wire INPUT_PATH_SELECT,
  input wire SLEEP_REQUEST,
  input wire [9:0] CLAMP_LEVEL_CODE,
  input wire FAST_LEADIN_ACTIVE,
  input wire SOFT_RESET_N,
  input wire CENTER_BIAS_OFF,
  input wire OB_STROBE,
  input wire DATA_VALID,
  input wire DATA_IS_REFERENCE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  property p_clamp;
    CLAMP_LEVEL_CODE[0] == 1'b0 && CLAMP_LEVEL_CODE inside {[10'h00E:10'h04C]};
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp code off grid");
  property p_rst;
    $rose(NRST) |-> CLAMP_LEVEL_CODE == 10'h020 && SOFT_RESET_N;
  endproperty
  a_rst: assert property (p_rst) else $error("bad values after reset");
  property p_cbias;
    CENTER_BIAS_OFF |-> INPUT_PATH_SELECT;
  endproperty
  a_cbias: assert property (p_cbias) else $error("bias off outside direct");
  property p_vpulse;
    DATA_VALID |=> !DATA_VALID;
  endproperty
  a_vpulse: assert property (p_vpulse) else $error("valid longer than one");
  property p_obp;
    OB_STROBE |=> !OB_STROBE;
  endproperty
  a_obp: assert property (p_obp) else $error("black strobe too long");
  property p_sleep;
    SLEEP_REQUEST && $past(SLEEP_REQUEST) |-> !DATA_VALID;
  endproperty
  a_sleep: assert property (p_sleep) else $error("word while asleep");
  property p_soft;
    !SOFT_RESET_N && !$past(SOFT_RESET_N) |-> !DATA_VALID;
  endproperty
  a_soft: assert property (p_soft) else $error("word in soft reset");
  // a gain change needs a frame under chip select
  property p_frame;
    $changed(GAIN_CODE) |-> $past(SERIAL_CS_N, 6) == 1'b0;
  endproperty
  a_frame: assert property (p_frame) else $error("gain changed w/o frame");
  c_ref: cover property (DATA_VALID && DATA_IS_REFERENCE);
  c_lead: cover property (FAST_LEADIN_ACTIVE);
  c_ob: cover property (OB_STROBE);
endmodule

bind cac_config cac_props u_props (.CLOCK, .NRST, .SERIAL_CS_N, .GAIN_CODE,
  .INPUT_PATH_SELECT, .SLEEP_REQUEST, .CLAMP_LEVEL_CODE, .FAST_LEADIN_ACTIVE,
  .SOFT_RESET_N, .CENTER_BIAS_OFF, .OB_STROBE, .DATA_VALID, .DATA_IS_REFERENCE);

// File: cac_host.sv
/*
  cac_host.sv: host controller model writing frames on the serial link.
  assumes clk is the bench clock; 160 ns serial period from 4+4 cycles.
*/
`timescale 1ns/10ps
module cac_host (
  // clock
  input wire clk,
  // serial pins
  output logic cs_n,
  output logic sck,
  output logic sdi
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // n below 16 aborts the frame early
  task automatic send(input logic [15:0] w, input int n);
    repeat (4) @(negedge clk);
    cs_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      sdi = w[i];
      repeat (4) @(negedge clk);
      sck = 1'b1;
      repeat (4) @(negedge clk);
      sck = 1'b0;
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    // released line, no pull: show the inverse, not a stale level
    sdi = ~sdi;
  endtask
endmodule

// File: tb.sv
/*
  tb.sv: self-checking bench for cac_config.
  assumes cac_host as writer and cac_props bound to the design.
*/
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cvc = 1'b0;
  logic sp = 1'b1;
  logic ob = 1'b0;
  logic [9:0] code = 10'h000;
  logic [9:0] prev = 10'h000;
  logic [11:0] expq[$];
  logic [11:0] e;
  int fail_count = 0;
  int num_checks = 0;
  wire cs_n, sck, sdi, path, lp, cbo, ss, bs, pb, dv, dref, fla, sb;
  wire [7:0] gain;
  wire [9:0] clamp, dout;
  always #10 clk = ~clk;
  cac_host u_host (.clk(clk), .cs_n(cs_n), .sck(sck), .sdi(sdi));
  cac_config u_dut (.CLOCK(clk), .NRST(nrst), .SERIAL_CS_N(cs_n), .SERIAL_CLK(sck),
    .SERIAL_DATA_IN(sdi), .CONVERTER_CLOCK(cvc), .SIGNAL_SAMPLE_PULSE(sp),
    .BLACK_SAMPLE_PULSE(sp), .PREBLANK_INPUT(sp), .OPTICAL_BLACK_PULSE(ob),
    .ADC_CODE(code), .GAIN_CODE(gain), .INPUT_PATH_SELECT(path), .SLEEP_REQUEST(),
    .STANDBY_REQUEST(sb), .OUTPUT_TEST_BITS(), .SH_FILTER_SELECT(),
    .BLACK_SAMPLE_TIME_CONSTANT(), .CLAMP_LEVEL_CODE(clamp),
    .FAST_LEADIN_CANCEL_TIME(), .FAST_LEADIN_GAIN_MULTIPLIER(),
    .FAST_LEADIN_ACTIVE(fla), .LOW_POWER_SELECT(lp), .SOFT_RESET_N(),
    .CENTER_BIAS_OFF(cbo), .CLAMP_FOUR_LINE_AVERAGE(), .OUTPUT_TEST_BIT_C(),
    .SIGNAL_SAMPLE(ss), .BLACK_SAMPLE(bs), .PREBLANK(pb), .OB_STROBE(),
    .DATA_OUT(dout), .DATA_VALID(dv), .DATA_IS_REFERENCE(dref));
  task automatic chk_reg(input logic [9:0] g, input logic [9:0] x);
    num_checks++;
    if (g !== x) begin
      fail_count++;
      $display("BAD %0t reg got %h exp %h", $time, g, x);
    end
  endtask
  // e[11] says whether the reference flag matters
  task automatic chk_word(input logic [11:0] x, input logic [10:0] g);
    num_checks++;
    if (x[9:0] !== g[9:0] || (x[11] && x[10] !== g[10])) begin
      fail_count++;
      $display("BAD %0t word got %h exp %h", $time, g, x[10:0]);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] w);
    u_host.send(w, 16);
    repeat (8) @(negedge clk);
  endtask
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (5) @(negedge clk);
      cvc = 1'b1;
      repeat (5) @(negedge clk);
      cvc = 1'b0;
    end
  endtask
  // timing code follows the mode, so each code is visited once
  task automatic run_line(input logic [1:0] m);
    logic [9:0] d;
    logic r;
    wr({7'h00, m, 1'b0, m, 4'h3});
    for (int p = 1; p < 10; p++) begin
      code = $urandom;
      ob = (p == 1);
      repeat (5) @(negedge clk);
      cvc = 1'b1;
      r = (p == 3 + m) || (p == 4 + m);
      d = (m[1] && !r) ? code - prev : code;
      if (m[0]) d = d ^ (d >> 1);
      expq.push_back({m[1], r, d});
      prev = code;
      repeat (5) @(negedge clk);
      cvc = 1'b0;
    end
  endtask
  // sampled at the falling edge, where the registered outputs have settled
  always @(negedge clk) begin
    if (dv === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : 12'hXXX;
      chk_word(e, {dref, dout});
    end
  end
  initial begin
    #400000;
    fail_count++;
    $display("BAD %0t timeout", $time);
    tally_and_finish;
  end
  initial begin
    logic [7:0] g;
    logic [4:0] f;
    logic pth, pol, lpw;
    void'($urandom(92));
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk_reg(clamp, 10'h020);
    repeat (4) begin
      g = $urandom;
      pth = $urandom;
      wr({pth, 2'b00, g, 5'h00});
      chk_reg(gain, g);
      chk_reg(path, pth);
    end
    u_host.send(16'hFFE0, 9);
    wr(16'hFFE5);
    chk_reg(gain, g);
    wr(16'h000B);
    chk_reg(cbo, pth);
    repeat (3) begin
      f = $urandom;
      pol = $urandom;
      lpw = $urandom;
      wr({2'b10, pol, lpw, 4'h0, f, 3'h2});
      chk_reg(clamp, {4'h0, f, 1'b0} + 10'h00E);
      chk_reg(lp, lpw);
      chk_reg({ss, bs, pb}, {3{pol}});
    end
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      wr({3'b000, g + 8'(m), 5'h00});
      run_line(m[1:0]);
      if (m > 0) chk_reg(fla, 10'h001);
    end
    $display("test coding done");
    wr(16'h0011);
    chk_reg(sb, 10'h001);
    wr(16'h0009);
    toggle(3);
    wr(16'h0001);
    wr(16'h2002);
    toggle(3);
    wr(16'hA04A);
    repeat (20) @(negedge clk);
    chk_reg(10'(expq.size()), 10'h000);
    $display("test power done");
    tally_and_finish;
  end
endmodule
